// File: src/ipr_pkg.sv
// Purpose: Shared constants for the paired-register I2C expander link
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes:   Register indices are command byte values
package ipr_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] IPR_REG_IN_LOW   = 8'h00;
	localparam logic [7:0] IPR_REG_IN_HIGH  = 8'h01;
	localparam logic [7:0] IPR_REG_OUT_LOW  = 8'h02;
	localparam logic [7:0] IPR_REG_OUT_HIGH = 8'h03;
	localparam logic [7:0] IPR_OUT_RESET    = 8'hff;
	localparam int         IPR_NUM_PAIRS    = 11;

	// ------------------------------------------------------------
	// Bus framing
	// ------------------------------------------------------------
	localparam logic [6:0] IPR_DEV_ADDR     = 7'h20;
	localparam logic       IPR_RW_WRITE     = 1'b0;
	localparam logic       IPR_RW_READ      = 1'b1;
	localparam logic [3:0] IPR_LAST_BIT     = 4'h7;
	localparam logic [3:0] IPR_ACK_SLOT     = 4'h8;

	// ------------------------------------------------------------
	// Controller timing
	// ------------------------------------------------------------
	localparam int         IPR_CLK_NS       = 10;
	localparam int         IPR_QTR_NS       = 250;
	localparam logic [7:0] IPR_QTR_CYC      = 8'((IPR_QTR_NS + IPR_CLK_NS - 1) / IPR_CLK_NS);

	// Partner register of a pair: flip bit 0
	function automatic logic [7:0] ipr_partner(input logic [7:0] ptr);
		return {ptr[7:1], ~ptr[0]};
	endfunction : ipr_partner

endpackage : ipr_pkg

// File: src/ipr_bus_if.sv
// Purpose: Two-wire bus joining controller and expander
// Assumes: Open-drain wires with pull-ups resolved here
// Notes:   Output enables are active low (low = pulling the wire low)
`timescale 1ns/10ps
interface ipr_bus_if;
	logic scl_oe_n_ctl;
	logic sda_oe_n_ctl;
	logic sda_oe_n_dev;
	logic scl;
	logic sda;

	assign scl = scl_oe_n_ctl;
	assign sda = sda_oe_n_ctl & sda_oe_n_dev;

	modport device     (input scl, input sda, output sda_oe_n_dev);
	modport controller (input scl, input sda, output scl_oe_n_ctl, output sda_oe_n_ctl);
endinterface : ipr_bus_if

// File: src/ipr_device.sv
// Purpose: Expander end: I2C responder with paired register pointer
// Assumes: Wires come from another domain and are synchronised here
// Notes:   Only input and output level pairs are backed by storage
`timescale 1ns/10ps

module ipr_device (
	input  wire logic        clk,
	input  wire logic        reset,
	ipr_bus_if.device        bus,
	input  wire logic [15:0] pins_in,
	output logic      [15:0] pins_out,
	output logic      [7:0]  pointer
);

	typedef enum {IPR_D_IDLE, IPR_D_ADDR, IPR_D_CMD, IPR_D_WDATA, IPR_D_RDATA, IPR_D_WAIT}
		ipr_dstate_t;

	// ------------------------------------------------------------
	// Synchronisers and edge detection
	// ------------------------------------------------------------
	logic [1:0] scl_s_r;
	logic [1:0] sda_s_r;
	logic       scl_d_r;
	logic       sda_d_r;
	logic [15:0] pin_s1_r;
	logic [15:0] pin_s2_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			scl_s_r  <= 2'h3;
			sda_s_r  <= 2'h3;
			scl_d_r  <= 1'b1;
			sda_d_r  <= 1'b1;
			pin_s1_r <= 16'h0000;
			pin_s2_r <= 16'h0000;
		end else begin
			scl_s_r  <= {scl_s_r[0], bus.scl};
			sda_s_r  <= {sda_s_r[0], bus.sda};
			scl_d_r  <= scl_s_r[1];
			sda_d_r  <= sda_s_r[1];
			pin_s1_r <= pins_in;
			pin_s2_r <= pin_s1_r;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	assign scl_rise = scl_s_r[1] & ~scl_d_r;
	assign scl_fall = ~scl_s_r[1] & scl_d_r;
	assign start_ev = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
	assign stop_ev  = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

	// ------------------------------------------------------------
	// Protocol state
	// ------------------------------------------------------------
	ipr_dstate_t state_r;
	logic [3:0]  bit_r;
	logic [7:0]  shift_r;
	logic [7:0]  tx_r;
	logic [7:0]  ptr_r;
	logic [7:0]  out_low_r;
	logic [7:0]  out_high_r;
	logic        sda_oe_n_r;
	logic        in_ack_r;

	// Register read mux; unbacked pairs read zero
	function automatic logic [7:0] read_reg(input logic [7:0] p, input logic [15:0] pins,
		input logic [7:0] lo, input logic [7:0] hi);
		case (p)
			ipr_pkg::IPR_REG_IN_LOW:   return pins[7:0];
			ipr_pkg::IPR_REG_IN_HIGH:  return pins[15:8];
			ipr_pkg::IPR_REG_OUT_LOW:  return lo;
			ipr_pkg::IPR_REG_OUT_HIGH: return hi;
			default:                   return 8'h00;
		endcase
	endfunction : read_reg

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r    <= IPR_D_IDLE;
			bit_r      <= 4'h0;
			shift_r    <= 8'h00;
			tx_r       <= 8'h00;
			ptr_r      <= ipr_pkg::IPR_REG_IN_LOW;
			out_low_r  <= ipr_pkg::IPR_OUT_RESET;
			out_high_r <= ipr_pkg::IPR_OUT_RESET;
			sda_oe_n_r <= 1'b1;
			in_ack_r   <= 1'b0;
		end else if (start_ev) begin
			// Repeated start keeps the pointer
			state_r    <= IPR_D_ADDR;
			bit_r      <= 4'h0;
			sda_oe_n_r <= 1'b1;
			in_ack_r   <= 1'b0;
		end else if (stop_ev) begin
			// Partially shifted byte is simply dropped
			state_r    <= IPR_D_IDLE;
			bit_r      <= 4'h0;
			sda_oe_n_r <= 1'b1;
			in_ack_r   <= 1'b0;
		end else begin
			case (state_r)
				IPR_D_IDLE, IPR_D_WAIT: begin
					sda_oe_n_r <= 1'b1;
				end
				IPR_D_ADDR, IPR_D_CMD, IPR_D_WDATA: begin
					if (scl_rise && !in_ack_r) begin
						shift_r <= {shift_r[6:0], sda_s_r[1]};
						bit_r   <= bit_r + 4'h1;
					end
					if (scl_fall && !in_ack_r && bit_r == ipr_pkg::IPR_ACK_SLOT) begin
						in_ack_r <= 1'b1;
						bit_r    <= 4'h0;
						if (state_r == IPR_D_ADDR) begin
							if (shift_r[7:1] == ipr_pkg::IPR_DEV_ADDR) begin
								sda_oe_n_r <= 1'b0;
								if (shift_r[0] == ipr_pkg::IPR_RW_READ) begin
									state_r <= IPR_D_RDATA;
								end else begin
									state_r <= IPR_D_CMD;
								end
							end else begin
								in_ack_r <= 1'b0;
								state_r  <= IPR_D_WAIT;
							end
						end else if (state_r == IPR_D_CMD) begin
							ptr_r      <= shift_r;
							sda_oe_n_r <= 1'b0;
							state_r    <= IPR_D_WDATA;
						end else begin
							// Any number of bytes, each to the partner next
							case (ptr_r)
								ipr_pkg::IPR_REG_OUT_LOW:  out_low_r  <= shift_r;
								ipr_pkg::IPR_REG_OUT_HIGH: out_high_r <= shift_r;
								default:                   ;
							endcase
							ptr_r      <= ipr_pkg::ipr_partner(ptr_r);
							sda_oe_n_r <= 1'b0;
						end
					end else if (scl_fall && in_ack_r) begin
						in_ack_r   <= 1'b0;
						sda_oe_n_r <= 1'b1;
					end
				end
				IPR_D_RDATA: begin
					if (in_ack_r) begin
						// Address ack: load first byte from pointer
						if (scl_rise) begin
							tx_r <= read_reg(ptr_r, pin_s2_r, out_low_r, out_high_r);
						end
						if (scl_fall) begin
							in_ack_r   <= 1'b0;
							bit_r      <= 4'h0;
							sda_oe_n_r <= tx_r[7];
						end
					end else begin
						if (scl_fall && bit_r < ipr_pkg::IPR_LAST_BIT) begin
							sda_oe_n_r <= tx_r[3'(ipr_pkg::IPR_LAST_BIT - bit_r - 4'h1)];
							bit_r      <= bit_r + 4'h1;
						end else if (scl_fall && bit_r == ipr_pkg::IPR_LAST_BIT) begin
							sda_oe_n_r <= 1'b1;
							bit_r      <= ipr_pkg::IPR_ACK_SLOT;
							ptr_r      <= ipr_pkg::ipr_partner(ptr_r);
						end else if (scl_rise && bit_r == ipr_pkg::IPR_ACK_SLOT) begin
							if (sda_s_r[1]) begin
								state_r <= IPR_D_WAIT;
							end else begin
								// Capture on ack rising edge, keep going
								tx_r     <= read_reg(ptr_r, pin_s2_r, out_low_r, out_high_r);
								in_ack_r <= 1'b1;
							end
						end
					end
				end
				default: state_r <= IPR_D_IDLE;
			endcase
		end
	end

	assign bus.sda_oe_n_dev = sda_oe_n_r;
	assign pins_out         = {out_high_r, out_low_r};
	assign pointer          = ptr_r;

endmodule : ipr_device

// File: src/ipr_controller.sv
// Purpose: Controller end: issues register writes and reads
// Assumes: Drives SCL itself, so one clock domain
// Notes:   Write bursts use one command then data bytes; reads may skip the command
`timescale 1ns/10ps
module ipr_controller (
	input  wire logic        clk,
	input  wire logic        reset,
	ipr_bus_if.controller    bus,
	input  wire logic        req,
	input  wire logic        req_read,
	input  wire logic        req_set_cmd,
	input  wire logic [7:0]  req_cmd,
	input  wire logic [7:0]  req_count,
	input  wire logic [7:0]  wr_data,
	output logic             wr_take,
	output logic             busy,
	output logic [7:0]       rd_data,
	output logic             rd_valid
);

	typedef enum {IPR_C_IDLE, IPR_C_START, IPR_C_BYTE, IPR_C_ACK, IPR_C_STOP} ipr_cstate_t;
	typedef enum {IPR_P_WADDR, IPR_P_CMD, IPR_P_RADDR, IPR_P_WDATA, IPR_P_RDATA} ipr_phase_t;

	ipr_cstate_t state_r;
	ipr_phase_t  phase_r;
	logic [7:0]  tick_r;
	logic [1:0]  qtr_r;
	logic [3:0]  bit_r;
	logic [7:0]  sh_r;
	logic [7:0]  left_r;
	logic        rd_r;
	logic        scl_r;
	logic        sda_r;
	logic        took_r;
	logic        rv_r;

	logic step;
	assign step = (tick_r == ipr_pkg::IPR_QTR_CYC - 8'h01);

	always_ff @(posedge clk) begin
		if (reset || state_r == IPR_C_IDLE || step) tick_r <= 8'h00;
		else tick_r <= tick_r + 8'h01;
	end

	// ------------------------------------------------------------
	// Sequencer: four quarter periods per bit
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		took_r <= 1'b0;
		rv_r   <= 1'b0;
		if (reset) begin
			state_r <= IPR_C_IDLE;
			phase_r <= IPR_P_WADDR;
			qtr_r   <= 2'h0;
			bit_r   <= 4'h0;
			sh_r    <= 8'h00;
			left_r  <= 8'h00;
			rd_r    <= 1'b0;
			scl_r   <= 1'b1;
			sda_r   <= 1'b1;
			rd_data <= 8'h00;
		end else case (state_r)
			IPR_C_IDLE: if (req) begin
				rd_r    <= req_read;
				left_r  <= req_count;
				qtr_r   <= 2'h0;
				state_r <= IPR_C_START;
				// Writes and command reads begin with a write address
				if (!req_read || req_set_cmd) begin
					phase_r <= IPR_P_WADDR;
					sh_r    <= {ipr_pkg::IPR_DEV_ADDR, ipr_pkg::IPR_RW_WRITE};
				end else begin
					phase_r <= IPR_P_RADDR;
					sh_r    <= {ipr_pkg::IPR_DEV_ADDR, ipr_pkg::IPR_RW_READ};
				end
			end
			IPR_C_START: if (step) begin
				qtr_r <= qtr_r + 2'h1;
				case (qtr_r)
					2'h0: sda_r <= 1'b1;
					2'h1: scl_r <= 1'b1;
					2'h2: sda_r <= 1'b0;
					default: begin
						scl_r   <= 1'b0;
						bit_r   <= 4'h0;
						state_r <= IPR_C_BYTE;
					end
				endcase
			end
			IPR_C_BYTE: if (step) begin
				qtr_r <= qtr_r + 2'h1;
				case (qtr_r)
					2'h0: sda_r <= (phase_r == IPR_P_RDATA) ? 1'b1 : sh_r[7];
					2'h1: scl_r <= 1'b1;
					2'h2: if (phase_r == IPR_P_RDATA) sh_r <= {sh_r[6:0], bus.sda};
					default: begin
						scl_r <= 1'b0;
						if (phase_r != IPR_P_RDATA) sh_r <= {sh_r[6:0], 1'b0};
						bit_r <= bit_r + 4'h1;
						if (bit_r == ipr_pkg::IPR_LAST_BIT) state_r <= IPR_C_ACK;
					end
				endcase
			end
			IPR_C_ACK: if (step) begin
				qtr_r <= qtr_r + 2'h1;
				case (qtr_r)
					// NACK only on the final read byte
					2'h0: sda_r <= (phase_r == IPR_P_RDATA) ? (left_r == 8'h01) : 1'b1;
					2'h1: scl_r <= 1'b1;
					2'h2: if (phase_r == IPR_P_RDATA) begin
						rd_data <= sh_r;
						rv_r    <= 1'b1;
					end
					default: begin
						scl_r <= 1'b0;
						bit_r <= 4'h0;
						state_r <= IPR_C_BYTE;
						case (phase_r)
							IPR_P_WADDR: begin
								phase_r <= IPR_P_CMD;
								sh_r    <= req_cmd;
							end
							IPR_P_CMD: if (rd_r) begin
								phase_r <= IPR_P_RADDR;
								sh_r    <= {ipr_pkg::IPR_DEV_ADDR, ipr_pkg::IPR_RW_READ};
								state_r <= IPR_C_START;
							end else if (left_r == 8'h00) begin
								state_r <= IPR_C_STOP;
							end else begin
								phase_r <= IPR_P_WDATA;
								sh_r    <= wr_data;
								// Count still holds this first data byte
								took_r  <= 1'b1;
							end
							IPR_P_RADDR: phase_r <= IPR_P_RDATA;
							default: if (left_r <= 8'h01) begin
								state_r <= IPR_C_STOP;
							end else begin
								left_r <= left_r - 8'h01;
								if (phase_r == IPR_P_WDATA) begin
									sh_r   <= wr_data;
									took_r <= 1'b1;
								end
							end
						endcase
					end
				endcase
			end
			IPR_C_STOP: if (step) begin
				qtr_r <= qtr_r + 2'h1;
				case (qtr_r)
					2'h0: sda_r <= 1'b0;
					2'h1: scl_r <= 1'b1;
					2'h2: sda_r <= 1'b1;
					default: state_r <= IPR_C_IDLE;
				endcase
			end
			default: state_r <= IPR_C_IDLE;
		endcase
	end

	assign bus.scl_oe_n_ctl = scl_r;
	assign bus.sda_oe_n_ctl = sda_r;
	assign wr_take          = took_r;
	assign rd_valid         = rv_r;
	assign busy             = (state_r != IPR_C_IDLE);

endmodule : ipr_controller

// File: verification/ipr_bus_properties.sv
// Purpose: Bus-level checks between the controller and expander ends
// Assumes: Open-drain wires resolved in the interface, one clock
// Notes:   Bit and byte positions are tracked from SCL rises
`timescale 1ns/10ps
module ipr_bus_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl_oe_n_ctl,
	input wire logic sda_oe_n_ctl,
	input wire logic sda_oe_n_dev,
	input wire logic scl,
	input wire logic sda
);
	logic [3:0] bit_cnt_r;
	logic [7:0] byte_cnt_r;
	logic [7:0] shift_r;
	logic       rd_r;
	logic       ack_slot;
	logic       rd_byte;
	logic       addr_hit;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	assign ack_slot = (bit_cnt_r == 4'h8);
	assign rd_byte  = rd_r && (byte_cnt_r != 8'h00);
	assign addr_hit = (shift_r[7:1] == ipr_pkg::IPR_DEV_ADDR);

	// ------------------------------------------------------------
	// Frame tracking
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset || (scl && $fell(sda))) begin
			bit_cnt_r  <= 4'h0;
			byte_cnt_r <= 8'h00;
		end else if ($rose(scl)) begin
			bit_cnt_r  <= ack_slot ? 4'h0 : bit_cnt_r + 4'h1;
			byte_cnt_r <= ack_slot ? byte_cnt_r + 8'h01 : byte_cnt_r;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			shift_r <= 8'h00;
		end else if ($rose(scl) && !ack_slot) begin
			shift_r <= {shift_r[6:0], sda};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rd_r <= 1'b0;
		end else if ($rose(scl) && ack_slot && byte_cnt_r == 8'h00) begin
			rd_r <= shift_r[0];
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	reset_release_a: assert property (
		$fell(reset) |-> scl_oe_n_ctl && sda_oe_n_ctl && sda_oe_n_dev)
		else $error("bus not released after reset");
	dev_hold_a: assert property (
		scl && $past(scl) |-> $stable(sda_oe_n_dev))
		else $error("device moved SDA while SCL high");
	addr_ack_a: assert property (
		$rose(scl) && ack_slot && byte_cnt_r == 8'h00 && addr_hit |-> !sda)
		else $error("address not acknowledged");
	write_ack_a: assert property (
		$rose(scl) && ack_slot && byte_cnt_r != 8'h00 && !rd_r |-> !sda)
		else $error("written byte not acknowledged");
	ack_lag_a: assert property (
		$fell(scl) && ack_slot && (byte_cnt_r == 8'h00 ? addr_hit : !rd_r)
		|-> ##[1:8] !sda_oe_n_dev)
		else $error("acknowledge driven late");
	ctl_release_a: assert property (
		scl && $past(scl) && rd_byte && bit_cnt_r > 4'h1 |-> sda_oe_n_ctl)
		else $error("controller drove SDA in read data");
	nack_release_a: assert property (
		$rose(scl) && ack_slot && rd_byte && sda |-> ##55 sda_oe_n_dev [*8])
		else $error("device drove SDA after NACK");
	scl_high_a: assert property (
		$rose(scl) |-> scl [*8])
		else $error("SCL high phase too short");

	cover property ($rose(scl) && ack_slot && rd_byte && sda);
	cover property ($rose(scl) && ack_slot && !rd_r && byte_cnt_r == 8'h03);
	cover property ($rose(scl) && ack_slot && byte_cnt_r == 8'h00 && shift_r[0]);
endmodule : ipr_bus_properties

// File: verification/i2c_paired_register_access_tb.sv
// Purpose: Self-checking bench joining both ends of the expander link
// Assumes: 100 MHz clock, synchronous reset held 6 cycles
// Notes:   Expected bytes come from a small register model
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module i2c_paired_register_access_tb;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        req = 1'b0;
	logic        req_read = 1'b0;
	logic        req_set_cmd = 1'b0;
	logic [7:0]  req_cmd = 8'h00;
	logic [7:0]  req_count = 8'h00;
	logic [7:0]  wr_data = 8'h00;
	logic [15:0] pins_in = 16'h5a3c;
	logic [15:0] pins_new = 16'h0000;
	logic [15:0] pins_out;
	logic [7:0]  pointer;
	logic [7:0]  rd_data;
	logic        wr_take;
	logic        busy;
	logic        rd_valid;
	logic [31:0] seed = 32'h0d138f95;
	int          err_count = 0;
	int          comparisons = 0;
	int          t;
	logic [7:0]  r;
	logic [7:0]  wq[$];
	logic [7:0]  rq[$];
	logic [15:0] out_m = 16'hffff;
	logic [7:0]  ptr_m = 8'h00;

	always #5 clk = ~clk;

	ipr_bus_if ipr_bus_if_i ();
	ipr_device ipr_device_i (.clk(clk), .reset(reset), .bus(ipr_bus_if_i.device),
		.pins_in(pins_in), .pins_out(pins_out), .pointer(pointer));
	ipr_controller ipr_controller_i (.clk(clk), .reset(reset),
		.bus(ipr_bus_if_i.controller), .req(req), .req_read(req_read),
		.req_set_cmd(req_set_cmd), .req_cmd(req_cmd), .req_count(req_count),
		.wr_data(wr_data), .wr_take(wr_take), .busy(busy), .rd_data(rd_data),
		.rd_valid(rd_valid));
	ipr_bus_properties ipr_bus_properties_i (.clk(clk), .reset(reset),
		.scl_oe_n_ctl(ipr_bus_if_i.scl_oe_n_ctl), .sda_oe_n_ctl(ipr_bus_if_i.sda_oe_n_ctl),
		.sda_oe_n_dev(ipr_bus_if_i.sda_oe_n_dev), .scl(ipr_bus_if_i.scl),
		.sda(ipr_bus_if_i.sda));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	function automatic logic [7:0] exp_rd(input logic [7:0] p, input logic [15:0] pv);
		case (p)
			8'h00: return pv[7:0];
			8'h01: return pv[15:8];
			8'h02: return out_m[7:0];
			8'h03: return out_m[15:8];
			default: return 8'h00;
		endcase
	endfunction : exp_rd

	task automatic stop_test();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	// Write sends wq after cmd; read collects n bytes and checks them
	task automatic xfer(input logic rd, input logic sc, input logic [7:0] cmd,
		input logic [7:0] n, input logic chg);
		int          i;
		int          k;
		logic [15:0] pv0;
		i = 0;
		rq.delete();
		@(posedge clk);
		pv0 = pins_in;
		req         <= 1'b1;
		req_read    <= rd;
		req_set_cmd <= sc;
		req_cmd     <= cmd;
		req_count   <= n;
		wr_data     <= (wq.size() > 0) ? wq[0] : 8'h00;
		@(posedge clk);
		req <= 1'b0;
		// Busy shows one edge after the request is taken
		@(posedge clk);
		for (k = 0; k < 20000 && busy === 1'b1; k++) begin
			@(posedge clk);
			if (wr_take === 1'b1 && i + 1 < wq.size()) begin
				i++;
				wr_data <= wq[i];
			end
			if (rd_valid === 1'b1) begin
				rq.push_back(rd_data);
				if (chg) pins_in <= pins_new;
			end
		end
		if (k >= 20000) begin
			err_count++;
			stop_test();
		end
		if (!rd || sc) ptr_m = cmd;
		foreach (wq[j]) begin
			if (ptr_m == 8'h02) out_m[7:0] = wq[j];
			if (ptr_m == 8'h03) out_m[15:8] = wq[j];
			ptr_m = ptr_m ^ 8'h01;
		end
		if (rd) begin
			`CHK(8'(rq.size()), n)
			foreach (rq[j]) begin
				`CHK(rq[j], exp_rd(ptr_m, (chg && j > 1) ? pins_new : pv0))
				ptr_m = ptr_m ^ 8'h01;
			end
		end
		`CHK(pointer, ptr_m)
		`CHK(pins_out, out_m)
	endtask : xfer

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK(pins_out, 16'hffff)
		for (t = 0; t < 6; t++) begin
			r = rnd();
			wq.delete();
			repeat (r[2:0]) wq.push_back(rnd());
			xfer(1'b0, 1'b0, {7'h01, r[3]}, {5'h00, r[2:0]}, 1'b0);
		end
		$display("test writes done");
		wq = '{rnd(), rnd()};
		xfer(1'b0, 1'b0, 8'h00, 8'h02, 1'b0);
		wq = '{rnd(), rnd(), rnd()};
		xfer(1'b0, 1'b0, 8'h06, 8'h03, 1'b0);
		wq.delete();
		xfer(1'b1, 1'b1, 8'h06, 8'h02, 1'b0);
		$display("test other pairs done");
		xfer(1'b1, 1'b1, 8'h03, 8'h03, 1'b0);
		xfer(1'b1, 1'b0, 8'h00, 8'h02, 1'b0);
		xfer(1'b1, 1'b1, 8'h02, 8'h01, 1'b0);
		$display("test reads done");
		pins_in  <= {rnd(), rnd()};
		pins_new <= {rnd(), rnd()};
		xfer(1'b1, 1'b1, 8'h00, 8'h03, 1'b1);
		xfer(1'b1, 1'b0, 8'h00, 8'h01, 1'b0);
		$display("test input capture done");
		@(posedge clk);
		req       <= 1'b1;
		req_read  <= 1'b0;
		req_cmd   <= 8'h02;
		req_count <= 8'h04;
		wr_data   <= rnd();
		@(posedge clk);
		req <= 1'b0;
		repeat (3200) @(posedge clk);
		reset <= 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK(pins_out, 16'hffff)
		`CHK(pointer, 8'h00)
		out_m = 16'hffff;
		ptr_m = 8'h00;
		xfer(1'b1, 1'b1, 8'h02, 8'h02, 1'b0);
		$display("test mid reset done");
		stop_test();
	end
endmodule : i2c_paired_register_access_tb
